// [hw/ulp_defines.svh]
`ifndef ULP_DEFINES_SVH
`define ULP_DEFINES_SVH

// Transmit command byte layout
`define ULP_CMD_MSB 7
`define ULP_CMD_LSB 6
`define ULP_ADDR_MSB 5
`define ULP_ADDR_LSB 0
`define ULP_CMD_XMIT 2'h1
`define ULP_CMD_REGW 2'h2
`define ULP_CMD_REGR 2'h3

// Function control register
`define ULP_FUNCTION_CONTROL_REGISTER_ADDR 6'h04
`define ULP_FUNCTION_CONTROL_REGISTER_RST 8'h41
`define ULP_SUSPEND_BIT 6
`define ULP_OTHER_REG_RST 8'h00
`define ULP_UNMAPPED_READ 8'h00

// Status byte and low-power bus layout
`define ULP_LS_LSB 0
`define ULP_LS_MSB 1
`define ULP_INT_BIT 3
`define ULP_BUS_IDLE 8'h00

// Interface clock rate
`define ULP_IFC_CLK_MHZ 60

`endif

// [hw/ulp_link_phy.sv]
`timescale 1ns/10ps
`include "ulp_defines.svh"

module ulp_link_phy
    import ulp_pkg::*;
#(
    parameter int REG_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ulpiClk,
    input wire logic [7:0] ulpiDataIn,
    output logic [7:0] ulpiDataOut,
    output logic ulpiDataOe,
    output logic ulpiDir,
    output logic ulpiNxt,
    input wire logic ulpiStp,
    input wire logic [1:0] lineState,
    input wire logic intSrc,
    input wire logic rxValid,
    input wire ulp_word_t rxWord,
    output logic rxReady,
    output logic txValid,
    output ulp_word_t txWord
);

    localparam int AW = $clog2(REG_DEPTH);

    // Core side, system clock
    logic rxReq_r, rxReq_nxt;
    ulp_word_t rxHold_r, rxHold_nxt;
    logic rxReady_r, rxReady_nxt;
    logic rxAckS1_r, rxAckS2_r;
    logic txReqS1_r, txReqS2_r;
    logic txAck_r, txAck_nxt;
    logic txValid_r, txValid_nxt;
    ulp_word_t txOut_r, txOut_nxt;
    logic intLevel_r;

    // Link side, interface clock
    logic uRstS1_r, uRst_r;
    logic rxReqS1_r, rxReqS2_r;
    logic txAckS1_r, txAckS2_r;
    logic intS1_r, intS2_r;
    logic [1:0] lsS1_r, lsS2_r;
    ulp_state_t st_r, st_nxt;
    logic dir_r, dir_nxt;
    logic nxt_r, nxt_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] dout_r, dout_nxt;
    logic rxAck_r, rxAck_nxt;
    logic txReq_r, txReq_nxt;
    ulp_word_t txBuf_r, txBuf_nxt;
    logic [5:0] regAddr_r, regAddr_nxt;
    logic [7:0] regData_r, regData_nxt;
    logic [7:0] regs_r [REG_DEPTH];
    logic [7:0] regs_nxt [REG_DEPTH];
    logic [2:0] lastRep_r, lastRep_nxt;
    logic inPkt_r, inPkt_nxt;
    logic drop_r, drop_nxt;
    logic lastOut_r, lastOut_nxt;
    logic lpMode_r, lpMode_nxt;

    logic rxAvail;
    logic txBusy;
    logic [2:0] curStat;
    logic statPend;
    logic regMapped;
    logic [7:0] readVal;
    logic [7:0] rxcmdByte;
    logic [7:0] lpByte;

    // Core side: word handshake toward the link, pulse out of the link
    always_comb begin
        rxReq_nxt = rxReq_r;
        rxHold_nxt = rxHold_r;
        if (rxValid && rxReady_r) begin
            rxReq_nxt = !rxReq_r;
            rxHold_nxt = rxWord;
        end
        rxReady_nxt = (rxReq_nxt == rxAckS2_r);
        txAck_nxt = txAck_r;
        txValid_nxt = 1'b0;
        txOut_nxt = txOut_r;
        if (txReqS2_r != txAck_r) begin
            txAck_nxt = txReqS2_r;
            txValid_nxt = 1'b1;
            txOut_nxt = txBuf_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxReq_r <= 1'b0;
            rxHold_r <= '0;
            rxReady_r <= 1'b0;
            rxAckS1_r <= 1'b0;
            rxAckS2_r <= 1'b0;
            txReqS1_r <= 1'b0;
            txReqS2_r <= 1'b0;
            txAck_r <= 1'b0;
            txValid_r <= 1'b0;
            txOut_r <= '0;
            intLevel_r <= 1'b0;
        end else begin
            rxReq_r <= rxReq_nxt;
            rxHold_r <= rxHold_nxt;
            rxReady_r <= rxReady_nxt;
            rxAckS1_r <= rxAck_r;
            rxAckS2_r <= rxAckS1_r;
            txReqS1_r <= txReq_r;
            txReqS2_r <= txReqS1_r;
            txAck_r <= txAck_nxt;
            txValid_r <= txValid_nxt;
            txOut_r <= txOut_nxt;
            intLevel_r <= intSrc;
        end
    end

    // Reset and slow levels reach the interface clock through two flops
    always_ff @(posedge ulpiClk) begin
        uRstS1_r <= rst;
        uRst_r <= uRstS1_r;
        rxReqS1_r <= rxReq_r;
        rxReqS2_r <= rxReqS1_r;
        txAckS1_r <= txAck_r;
        txAckS2_r <= txAckS1_r;
        intS1_r <= intLevel_r;
        intS2_r <= intS1_r;
        lsS1_r <= lineState;
        lsS2_r <= lsS1_r;
    end

    assign rxAvail = (rxReqS2_r != rxAck_r);
    assign txBusy = (txReq_r != txAckS2_r);
    assign curStat = {intS2_r, lsS2_r};
    assign statPend = (curStat != lastRep_r);
    assign regMapped = (32'(regAddr_r) < REG_DEPTH);
    assign readVal = regMapped ? regs_r[regAddr_r[AW-1:0]] : `ULP_UNMAPPED_READ;

    always_comb begin
        rxcmdByte = `ULP_BUS_IDLE;
        rxcmdByte[`ULP_LS_MSB:`ULP_LS_LSB] = lsS2_r;
        rxcmdByte[`ULP_INT_BIT] = intS2_r;
        lpByte = `ULP_BUS_IDLE;
        lpByte[`ULP_LS_MSB:`ULP_LS_LSB] = lineState;
        lpByte[`ULP_INT_BIT] = intLevel_r;
    end

    always_comb begin
        st_nxt = st_r;
        dir_nxt = dir_r;
        nxt_nxt = 1'b0;
        oe_nxt = oe_r;
        dout_nxt = dout_r;
        rxAck_nxt = rxAck_r;
        txReq_nxt = txReq_r;
        txBuf_nxt = txBuf_r;
        regAddr_nxt = regAddr_r;
        regData_nxt = regData_r;
        regs_nxt = regs_r;
        lastRep_nxt = lastRep_r;
        inPkt_nxt = inPkt_r;
        drop_nxt = drop_r;
        lastOut_nxt = lastOut_r;
        case (st_r)
            ST_IDLE: begin
                dir_nxt = 1'b0;
                oe_nxt = 1'b0;
                if (rxAvail && drop_r) begin
                    rxAck_nxt = rxReqS2_r;
                    if (rxHold_r.last) begin
                        drop_nxt = 1'b0;
                    end
                end else if (rxAvail || statPend) begin
                    dir_nxt = 1'b1;
                    st_nxt = ST_TURNUP;
                end else if (ulpiDataIn != `ULP_BUS_IDLE && !txBusy) begin
                    nxt_nxt = 1'b1;
                    st_nxt = ST_CMD;
                end
            end
            ST_CMD: begin
                if (ulpiStp) begin
                    st_nxt = ST_IDLE;
                end else begin
                    regAddr_nxt = ulpiDataIn[`ULP_ADDR_MSB:`ULP_ADDR_LSB];
                    case (ulpiDataIn[`ULP_CMD_MSB:`ULP_CMD_LSB])
                        `ULP_CMD_XMIT: begin
                            txReq_nxt = !txReq_r;
                            txBuf_nxt.last = 1'b0;
                            txBuf_nxt.data = ulpiDataIn;
                            st_nxt = ST_TXDATA;
                        end
                        `ULP_CMD_REGW: begin
                            nxt_nxt = 1'b1;
                            st_nxt = ST_REGW;
                        end
                        `ULP_CMD_REGR: begin
                            dir_nxt = 1'b1;
                            st_nxt = ST_RTURN;
                        end
                        default: begin
                            st_nxt = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_TXDATA: begin
                if (ulpiStp) begin
                    st_nxt = ST_TXEND;
                end else if (nxt_r) begin
                    txReq_nxt = !txReq_r;
                    txBuf_nxt.last = 1'b0;
                    txBuf_nxt.data = ulpiDataIn;
                end
                nxt_nxt = !ulpiStp && (txReq_nxt == txAckS2_r);
            end
            ST_TXEND: begin
                if (!txBusy) begin
                    txReq_nxt = !txReq_r;
                    txBuf_nxt.last = 1'b1;
                    txBuf_nxt.data = `ULP_BUS_IDLE;
                    st_nxt = ST_IDLE;
                end
            end
            ST_REGW: begin
                if (ulpiStp) begin
                    st_nxt = ST_IDLE;
                end else if (nxt_r) begin
                    regData_nxt = ulpiDataIn;
                    st_nxt = ST_REGWS;
                end
            end
            ST_REGWS: begin
                if (ulpiStp) begin
                    if (regMapped) begin
                        regs_nxt[regAddr_r[AW-1:0]] = regData_r;
                    end
                    st_nxt = ST_IDLE;
                    if (regAddr_r == `ULP_FUNCTION_CONTROL_REGISTER_ADDR && !regData_r[`ULP_SUSPEND_BIT]) begin
                        dir_nxt = 1'b1;
                        st_nxt = ST_LPTURN;
                    end
                end
            end
            ST_RTURN: begin
                dout_nxt = readVal;
                oe_nxt = 1'b1;
                st_nxt = ST_RDATA;
            end
            ST_RDATA: begin
                dir_nxt = 1'b0;
                oe_nxt = 1'b0;
                st_nxt = ST_TURNDN;
            end
            ST_TURNUP, ST_SEND: begin
                if (ulpiStp || lastOut_r) begin
                    dir_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    lastOut_nxt = 1'b0;
                    st_nxt = ST_TURNDN;
                    if (ulpiStp) begin
                        drop_nxt = inPkt_r;
                        inPkt_nxt = 1'b0;
                    end
                end else if (rxAvail) begin
                    dout_nxt = rxHold_r.data;
                    nxt_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    rxAck_nxt = rxReqS2_r;
                    inPkt_nxt = !rxHold_r.last;
                    lastOut_nxt = rxHold_r.last;
                    st_nxt = ST_SEND;
                end else if (statPend || inPkt_r) begin
                    dout_nxt = rxcmdByte;
                    oe_nxt = 1'b1;
                    lastRep_nxt = curStat;
                    st_nxt = ST_SEND;
                end else begin
                    dir_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    st_nxt = ST_TURNDN;
                end
            end
            ST_TURNDN: begin
                dir_nxt = 1'b0;
                oe_nxt = 1'b0;
                st_nxt = ST_IDLE;
            end
            ST_LPTURN: begin
                oe_nxt = 1'b1;
                st_nxt = ST_LP;
            end
            ST_LP: begin
                if (ulpiStp) begin
                    regs_nxt[AW'(`ULP_FUNCTION_CONTROL_REGISTER_ADDR)][`ULP_SUSPEND_BIT] = 1'b1;
                    dir_nxt = 1'b0;
                    oe_nxt = 1'b0;
                    st_nxt = ST_TURNDN;
                end
            end
            default: begin
                dir_nxt = 1'b0;
                oe_nxt = 1'b0;
                st_nxt = ST_IDLE;
            end
        endcase
        lpMode_nxt = (st_nxt == ST_LP);
    end

    always_ff @(posedge ulpiClk) begin
        if (uRst_r) begin
            st_r <= ST_IDLE;
            dir_r <= 1'b0;
            nxt_r <= 1'b0;
            oe_r <= 1'b0;
            dout_r <= `ULP_BUS_IDLE;
            rxAck_r <= 1'b0;
            txReq_r <= 1'b0;
            txBuf_r <= '0;
            regAddr_r <= '0;
            regData_r <= '0;
            for (int i = 0; i < REG_DEPTH; i++) begin
                regs_r[i] <= (i == int'(`ULP_FUNCTION_CONTROL_REGISTER_ADDR)) ? `ULP_FUNCTION_CONTROL_REGISTER_RST
                                                               : `ULP_OTHER_REG_RST;
            end
            lastRep_r <= '0;
            inPkt_r <= 1'b0;
            drop_r <= 1'b0;
            lastOut_r <= 1'b0;
            lpMode_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            dir_r <= dir_nxt;
            nxt_r <= nxt_nxt;
            oe_r <= oe_nxt;
            dout_r <= dout_nxt;
            rxAck_r <= rxAck_nxt;
            txReq_r <= txReq_nxt;
            txBuf_r <= txBuf_nxt;
            regAddr_r <= regAddr_nxt;
            regData_r <= regData_nxt;
            regs_r <= regs_nxt;
            lastRep_r <= lastRep_nxt;
            inPkt_r <= inPkt_nxt;
            drop_r <= drop_nxt;
            lastOut_r <= lastOut_nxt;
            lpMode_r <= lpMode_nxt;
        end
    end

    // Low-power bus bypasses the flop so it stays live with the clock stopped
    assign ulpiDataOut = lpMode_r ? lpByte : dout_r;
    assign ulpiDataOe = oe_r;
    assign ulpiDir = dir_r;
    assign ulpiNxt = nxt_r;
    assign rxReady = rxReady_r;
    assign txValid = txValid_r;
    assign txWord = txOut_r;

    a_abort_dir: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (dir_r && ulpiStp && (st_r == ST_SEND || st_r == ST_TURNUP)) |=> !dir_r)
        else $error("direction not dropped after abort");

    a_turn_rise: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        $rose(dir_r) |-> (!oe_r ##1 (dir_r && oe_r)))
        else $error("no clean turnaround after direction rose");

    a_turn_fall: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        $fell(dir_r) |-> (!oe_r && !nxt_r))
        else $error("bus driven while direction fell");

    a_lp_quiet: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        lpMode_r |-> (dir_r && !nxt_r && oe_r))
        else $error("bad pins in low power");

    a_lp_exit: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (st_r == ST_LP && ulpiStp) |=> (!dir_r && !lpMode_r) ##1 (st_r == ST_IDLE))
        else $error("stop did not wake device");

    a_suspend_entry: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (st_r == ST_REGWS && ulpiStp && regAddr_r == `ULP_FUNCTION_CONTROL_REGISTER_ADDR
         && !regData_r[`ULP_SUSPEND_BIT]) |-> ##2 (lpMode_r && dir_r))
        else $error("suspend write did not enter low power");

    a_read_data: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (st_r == ST_RTURN) |=> (dir_r && oe_r && !nxt_r && dout_r == $past(readVal))
        ##1 !dir_r)
        else $error("register read data not returned");

    a_nxt_data: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (dir_r && nxt_r) |-> (oe_r && $past(rxAvail) && rxAck_r != $past(rxAck_r)))
        else $error("next without a data byte");

    a_tx_take: assert property (@(posedge ulpiClk) disable iff (uRst_r)
        (st_r == ST_TXDATA && nxt_r && !ulpiStp) |=> (txReq_r != $past(txReq_r)
        && txBuf_r.data == $past(ulpiDataIn)))
        else $error("byte after next not taken");

endmodule

// [hw/ulp_pkg.sv]
package ulp_pkg;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } ulp_word_t;

    typedef enum logic [12:0] {
        ST_IDLE   = 13'h0001,
        ST_CMD    = 13'h0002,
        ST_TXDATA = 13'h0004,
        ST_TXEND  = 13'h0008,
        ST_REGW   = 13'h0010,
        ST_REGWS  = 13'h0020,
        ST_RTURN  = 13'h0040,
        ST_RDATA  = 13'h0080,
        ST_TURNUP = 13'h0100,
        ST_SEND   = 13'h0200,
        ST_TURNDN = 13'h0400,
        ST_LPTURN = 13'h0800,
        ST_LP     = 13'h1000
    } ulp_state_t;

endpackage

// [testbench/ulp_host.sv]
`timescale 1ns/10ps
`include "ulp_defines.svh"

module ulp_host (
    input wire logic ulpiClk,
    input wire logic [7:0] ulpiDataOut,
    input wire logic ulpiDataOe,
    input wire logic ulpiDir,
    input wire logic ulpiNxt,
    output logic [7:0] busWire,
    output logic ulpiStp
);
    logic [7:0] linkData = 8'h00;
    logic [7:0] junk = 8'h5A;
    logic dirPrev = 1'b0;
    logic inRead = 1'b0;
    logic quiet = 1'b0;
    logic [7:0] lastStatus = 8'h00;
    logic [7:0] rxQ[$];
    int errs = 0;

    initial ulpiStp = 1'b0;

    // link drives only with direction low, after turnaround
    always_comb begin
        if (ulpiDataOe)
            busWire = ulpiDataOut;
        else if (!ulpiDir && !dirPrev)
            busWire = linkData;
        else
            busWire = junk;
    end

    // Released bus toggles so a stale value never looks valid
    always @(posedge ulpiClk) begin
        dirPrev <= ulpiDir;
        junk <= ~junk;
        if (ulpiDir && ulpiDataOe && !quiet) begin
            if (ulpiNxt)
                rxQ.push_back(busWire);
            else if (!inRead)
                lastStatus <= busWire;
        end
    end

    // each byte is held until next is seen high
    task automatic sendByte(input logic [7:0] b);
        int n;
        linkData <= b;
        for (n = 0; n < 100; n++) begin
            @(posedge ulpiClk);
            if (ulpiNxt && !ulpiDir)
                break;
        end
        if (n == 100)
            errs++;
    endtask

    // one stop cycle after the last byte, bus back to idle
    task automatic stopPulse();
        linkData <= 8'h00;
        ulpiStp <= 1'b1;
        @(posedge ulpiClk);
        ulpiStp <= 1'b0;
    endtask

    task automatic regWrite(input logic [5:0] a, input logic [7:0] d);
        @(posedge ulpiClk);
        sendByte({`ULP_CMD_REGW, a});
        sendByte(d);
        stopPulse();
    endtask

    task automatic transmit(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1);
        @(posedge ulpiClk);
        sendByte(c);
        sendByte(b0);
        sendByte(b1);
        stopPulse();
    endtask

    task automatic regRead(input logic [5:0] a, output logic [7:0] d);
        int n;
        d = 8'h00;
        @(posedge ulpiClk);
        sendByte({`ULP_CMD_REGR, a});
        linkData <= 8'h00;
        inRead <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ulpiClk);
            if (ulpiDir && ulpiDataOe)
                break;
        end
        d = busWire;
        // read data comes with next low
        if (n == 20 || ulpiNxt !== 1'b0)
            errs++;
        @(posedge ulpiClk);
        inRead <= 1'b0;
    endtask

    // stop while the device owns the bus
    task automatic abortRx();
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge ulpiClk);
            if (ulpiDir && ulpiDataOe)
                break;
        end
        if (n == 100)
            errs++;
        ulpiStp <= 1'b1;
        @(posedge ulpiClk);
        ulpiStp <= 1'b0;
        #1;
    endtask

    // suspend control bit written to zero
    task automatic sleep();
        quiet <= 1'b1;
        regWrite(`ULP_FUNCTION_CONTROL_REGISTER_ADDR, 8'h01);
    endtask

    task automatic wake();
        int n;
        @(posedge ulpiClk);
        ulpiStp <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ulpiClk);
            if (!ulpiDir)
                break;
        end
        if (n == 50)
            errs++;
        ulpiStp <= 1'b0;
        quiet <= 1'b0;
    endtask
endmodule

// [testbench/ulp_link_phy_bench.sv]
`timescale 1ns/10ps

module ulp_link_phy_bench
    import ulp_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ulpiClk = 1'b0;
    logic ulpiRun = 1'b1;
    logic [7:0] busWire;
    logic [7:0] dOut;
    logic dOe;
    logic dir;
    logic nxt;
    logic stp;
    logic [1:0] lineState = 2'h0;
    logic intSrc = 1'b0;
    logic rxValid = 1'b0;
    ulp_word_t rxWord = '0;
    logic rxReady;
    logic txValid;
    ulp_word_t txWord;
    ulp_word_t txQ[$];
    logic [7:0] rd;
    int mismatches = 0;
    int nTests = 0;

    ulp_link_phy u_ulp_link_phy (.clk(clk), .rst(rst), .ulpiClk(ulpiClk), .ulpiDataIn(busWire),
        .ulpiDataOut(dOut), .ulpiDataOe(dOe), .ulpiDir(dir), .ulpiNxt(nxt), .ulpiStp(stp),
        .lineState(lineState), .intSrc(intSrc), .rxValid(rxValid), .rxWord(rxWord),
        .rxReady(rxReady), .txValid(txValid), .txWord(txWord));
    ulp_host u_ulp_host (.ulpiClk(ulpiClk), .ulpiDataOut(dOut), .ulpiDataOe(dOe),
        .ulpiDir(dir), .ulpiNxt(nxt), .busWire(busWire), .ulpiStp(stp));

    always #5 clk = ~clk;
    // Link clock can be stopped to model suspend
    initial begin
        #3;
        forever begin
            #24;
            if (ulpiRun)
                ulpiClk = ~ulpiClk;
        end
    end

    always @(posedge clk) begin
        if (txValid === 1'b1)
            txQ.push_back(txWord);
    end

    task automatic chkBit(input string name, input logic exp, input logic got);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chkWord(input string name, input logic [8:0] exp, input logic [8:0] got);
        nTests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", nTests, mismatches);
        if (mismatches == 0 && nTests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang(input string name);
        mismatches++;
        $display("CHECK FAILED %s expected done seen timeout", name);
        end_of_test();
    endtask

    task automatic sendRx(input ulp_word_t w);
        int n;
        @(posedge clk);
        rxWord <= w;
        rxValid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            #1;
            if (rxReady === 1'b1)
                break;
            @(posedge clk);
        end
        if (n == 200)
            hang("rx handshake");
        @(posedge clk);
        rxValid <= 1'b0;
    endtask

    task automatic waitStatus(input logic [7:0] exp);
        int n;
        for (n = 0; n < 200 && u_ulp_host.lastStatus !== exp; n++)
            @(posedge ulpiClk);
        chkWord("status byte", {1'b0, exp}, {1'b0, u_ulp_host.lastStatus});
    endtask

    task automatic testRegs();
        u_ulp_host.regWrite(6'h05, 8'hA5);
        u_ulp_host.regRead(6'h05, rd);
        chkWord("reg 5", 9'h0A5, {1'b0, rd});
        u_ulp_host.sendByte(8'h05);
        u_ulp_host.stopPulse();
        u_ulp_host.regRead(6'h05, rd);
        chkWord("reg 5 kept", 9'h0A5, {1'b0, rd});
        u_ulp_host.regRead(6'h04, rd);
        chkWord("function_control_register reset", 9'h041, {1'b0, rd});
        u_ulp_host.regWrite(6'h3F, 8'h5A);
        u_ulp_host.regRead(6'h3F, rd);
        chkWord("unmapped", 9'h000, {1'b0, rd});
        $display("test registers done");
    endtask

    task automatic testTx();
        int n;
        txQ.delete();
        u_ulp_host.transmit(8'h43, 8'h11, 8'h22);
        for (n = 0; n < 100 && txQ.size() < 4; n++)
            @(posedge clk);
        if (n == 100)
            hang("tx words");
        chkWord("tx cmd", 9'h043, txQ[0]);
        chkWord("tx b0", 9'h011, txQ[1]);
        chkWord("tx b1", 9'h022, txQ[2]);
        chkWord("tx end", 9'h100, txQ[3]);
        chkBit("dir after tx", 1'b0, dir);
        $display("test transmit done");
    endtask

    task automatic testRx();
        int n;
        u_ulp_host.rxQ.delete();
        sendRx({1'b0, 8'hC1});
        sendRx({1'b0, 8'hC2});
        sendRx({1'b1, 8'hC3});
        for (n = 0; n < 200 && (dir !== 1'b0 || u_ulp_host.rxQ.size() < 3); n++)
            @(posedge ulpiClk);
        if (n == 200)
            hang("rx bytes");
        chkWord("rx 0", 9'h0C1, {1'b0, u_ulp_host.rxQ[0]});
        chkWord("rx 1", 9'h0C2, {1'b0, u_ulp_host.rxQ[1]});
        chkWord("rx 2", 9'h0C3, {1'b0, u_ulp_host.rxQ[2]});
        $display("test receive done");
    endtask

    task automatic testStatus();
        @(posedge clk);
        lineState <= 2'h1;
        intSrc <= 1'b1;
        waitStatus(8'h09);
        $display("test status done");
    endtask

    task automatic testAbort();
        u_ulp_host.rxQ.delete();
        sendRx({1'b0, 8'hD1});
        u_ulp_host.abortRx();
        chkBit("dir after abort", 1'b0, dir);
        sendRx({1'b1, 8'hD2});
        repeat (20) @(posedge ulpiClk);
        chkWord("rx after abort", 9'h001, 9'(u_ulp_host.rxQ.size()));
        $display("test abort done");
    endtask

    task automatic testLowPower();
        int n;
        u_ulp_host.sleep();
        for (n = 0; n < 50 && (dir !== 1'b1 || dOe !== 1'b1); n++)
            @(posedge ulpiClk);
        if (n == 50)
            hang("lp entry");
        repeat (4) @(posedge ulpiClk);
        chkBit("lp dir", 1'b1, dir);
        chkBit("lp nxt", 1'b0, nxt);
        chkWord("lp bus", 9'h009, {1'b0, dOut});
        // Clock stopped: line state must still reach the bus
        ulpiRun = 1'b0;
        @(posedge clk);
        lineState <= 2'h2;
        intSrc <= 1'b0;
        repeat (5) @(posedge clk);
        chkWord("lp bus stopped", 9'h002, {1'b0, dOut});
        chkBit("lp dir stopped", 1'b1, dir);
        ulpiRun = 1'b1;
        repeat (4) @(posedge ulpiClk);
        u_ulp_host.wake();
        chkBit("dir after wake", 1'b0, dir);
        waitStatus(8'h02);
        u_ulp_host.regRead(6'h04, rd);
        chkWord("function_control_register after wake", 9'h041, {1'b0, rd});
        $display("test low power done");
    endtask

    initial begin
        #900000;
        hang("whole run");
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge ulpiClk);
        chkBit("idle dir", 1'b0, dir);
        chkBit("idle nxt", 1'b0, nxt);
        chkBit("idle oe", 1'b0, dOe);
        testRegs();
        testTx();
        testRx();
        testStatus();
        testAbort();
        testLowPower();
        chkWord("host timeouts", 9'h000, 9'(u_ulp_host.errs));
        end_of_test();
    end
endmodule
